// ===== updown_pkg_store.sv
package updown_pkg;
  // Clocking and scan timing
  localparam int CLK_MHZ = 100;
  localparam int SCAN_NS = 1000;
  localparam int SCAN_CYC = (SCAN_NS * CLK_MHZ) / 1000;
  localparam int SCAN_CNT_W = 8;
  localparam logic [SCAN_CNT_W-1:0] SCAN_LAST = SCAN_CNT_W'(SCAN_CYC - 1);

  // Parameter slot store
  localparam int NUM_SLOTS = 8;
  localparam int SLOT_IDX_W = 3;
  localparam int SLOT_W = 16;
  localparam int DATA_W = 32;
  localparam int WORD_SLOTS = 3;
  localparam int DWORD_SLOTS = 6;
  localparam logic [SLOT_W-1:0] SLOT_RST [NUM_SLOTS] = '{
    16'h0000, 16'h0064, 16'h0032, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000
  };

  // Register map (byte addresses)
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] SLOT_OFS = 12'h000;
  localparam logic [ADDR_W-1:0] SLOT_END_OFS = 12'h01c;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h020;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h024;
  localparam logic [ADDR_W-1:0] CUR_OFS = 12'h028;

  // Control fields
  localparam int CTRL_DWORD_BIT = 0;
  localparam int CTRL_BASE_LSB = 4;
  localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0000;

  // Status fields
  localparam int STAT_OUT_BIT = 0;
  localparam int STAT_LOADED_BIT = 1;
  localparam int STAT_HOLD_BIT = 2;
  localparam int STAT_BASE_ERR_BIT = 3;
  localparam int STAT_PRESET_BIT = 4;

  // Count ranges
  localparam logic [DATA_W-1:0] WORD_MAX = 32'h0000_ffff;
  localparam logic [DATA_W-1:0] DWORD_MAX = 32'hffff_ffff;
  localparam logic [DATA_W-1:0] CUR_RST = 32'h0000_0000;
endpackage

module param_slot_store
  import updown_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Write port
  input wire logic wr_en_i,
  input wire logic [updown_pkg::SLOT_IDX_W-1:0] wr_idx_i,
  input wire logic [updown_pkg::SLOT_W-1:0] wr_data_i,
  // All slots, slot n at bits n*SLOT_W
  output logic [updown_pkg::NUM_SLOTS*updown_pkg::SLOT_W-1:0] slots_o
);
  logic [SLOT_W-1:0] slot_r [NUM_SLOTS];

  // Volatile copy, reset restores program values
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        slot_r[i] <= SLOT_RST[i];
      end
    end else if (wr_en_i) begin
      slot_r[wr_idx_i] <= wr_data_i;
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_SLOTS; i++) begin
      slots_o[i*SLOT_W +: SLOT_W] = slot_r[i];
    end
  end
endmodule // param_slot_store

// ===== reversible_counter_block.sv
// What this block does
// - Preset held loads initial value, output off
// - Otherwise each count rising edge steps one
// - Direction high counts down
// - Direction low counts up
// - ON>=OFF: output on at value>=ON
// - ON>=OFF: output off at value<OFF
// - ON<OFF: on within [ON, OFF)
// - ON<OFF: off outside [ON, OFF)
// - Preset wins; count waits one scan
// - Width select: 16-bit or 32-bit range
// - Up count saturates at width maximum
// - Down count stops at zero
// - Slots hold initial, ON, OFF consecutively
// - Runtime values volatile, reset restores defaults
//
// The address map and the APB register port were decided locally.
module reversible_counter_block
  import updown_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // APB slave
  input wire logic [updown_pkg::ADDR_W-1:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [updown_pkg::DATA_W-1:0] pwdata_i,
  output logic [updown_pkg::DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Counter inputs
  input wire logic preset_load_input_i,
  input wire logic count_pulse_i,
  input wire logic dir_down_i,
  // Counter results
  output logic cmp_out_o,
  output logic [updown_pkg::DATA_W-1:0] cur_value_o
);

  // Input synchronisers
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic preset_s;
  logic count_s;
  logic down_s;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
    end else begin
      sync1_r <= {dir_down_i, count_pulse_i, preset_load_input_i};
      sync2_r <= sync1_r;
    end
  end

  assign preset_s = sync2_r[0];
  assign count_s = sync2_r[1];
  assign down_s = sync2_r[2];

  // Scan cycle divider
  logic [SCAN_CNT_W-1:0] scan_cnt_r;
  logic scan_tick_r;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      scan_cnt_r <= '0;
      scan_tick_r <= 1'b0;
    end else if (scan_cnt_r == SCAN_LAST) begin
      scan_cnt_r <= '0;
      scan_tick_r <= 1'b1;
    end else begin
      scan_cnt_r <= scan_cnt_r + SCAN_CNT_W'(1);
      scan_tick_r <= 1'b0;
    end
  end

  // Control register and slot store
  logic [DATA_W-1:0] ctrl_r;
  logic dword;
  logic [SLOT_IDX_W-1:0] base_idx;
  logic [NUM_SLOTS*SLOT_W-1:0] slots;
  logic slot_wr;
  logic [SLOT_IDX_W-1:0] slot_wr_idx;

  assign dword = ctrl_r[CTRL_DWORD_BIT];
  assign base_idx = ctrl_r[CTRL_BASE_LSB +: SLOT_IDX_W];

  param_slot_store u_store (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .wr_en_i(slot_wr),
    .wr_idx_i(slot_wr_idx),
    .wr_data_i(pwdata_i[SLOT_W-1:0]),
    .slots_o(slots)
  );

  // Value k of the group: 0 initial, 1 ON, 2 OFF
  function automatic logic [DATA_W-1:0] group_val(
    input logic [NUM_SLOTS*SLOT_W-1:0] s,
    input logic dw,
    input logic [SLOT_IDX_W-1:0] base,
    input logic [1:0] k
  );
    logic [SLOT_IDX_W-1:0] lo;
    logic [SLOT_IDX_W-1:0] hi;
    logic [SLOT_IDX_W-1:0] wi;
    lo = base + SLOT_IDX_W'({k, 1'b0});
    hi = lo + SLOT_IDX_W'(1);
    wi = base + SLOT_IDX_W'(k);
    if (dw) begin
      group_val = {s[hi*SLOT_W +: SLOT_W], s[lo*SLOT_W +: SLOT_W]};
    end else begin
      group_val = {16'h0000, s[wi*SLOT_W +: SLOT_W]};
    end
  endfunction

  // Threshold comparison with hysteresis
  function automatic logic cmp_next(
    input logic [DATA_W-1:0] v,
    input logic [DATA_W-1:0] on_t,
    input logic [DATA_W-1:0] off_t,
    input logic prev
  );
    if (on_t >= off_t) begin
      if (v >= on_t) begin
        cmp_next = 1'b1;
      end else if (v < off_t) begin
        cmp_next = 1'b0;
      end else begin
        cmp_next = prev;
      end
    end else begin
      // Window mode, on only inside [ON, OFF)
      cmp_next = (v >= on_t) && (v < off_t);
    end
  endfunction

  logic [DATA_W-1:0] max_v;
  logic [DATA_W-1:0] init_v;
  logic [DATA_W-1:0] on_v;
  logic [DATA_W-1:0] off_v;
  logic [DATA_W-1:0] init_lim;
  logic [DATA_W-1:0] on_lim;
  logic [DATA_W-1:0] off_lim;
  logic base_err;

  assign max_v = dword ? DWORD_MAX : WORD_MAX;
  assign init_v = group_val(slots, dword, base_idx, 2'd0);
  assign on_v = group_val(slots, dword, base_idx, 2'd1);
  assign off_v = group_val(slots, dword, base_idx, 2'd2);
  // Values clipped to the selected width
  assign init_lim = init_v & max_v;
  assign on_lim = on_v & max_v;
  assign off_lim = off_v & max_v;
  // Group running past the last slot wraps; flagged to software
  assign base_err = dword ?
    (4'(base_idx) + 4'(DWORD_SLOTS) > 4'(NUM_SLOTS)) :
    (4'(base_idx) + 4'(WORD_SLOTS) > 4'(NUM_SLOTS));

  // Scan sampling: previous count level and post-preset hold
  logic count_prev_r;
  logic hold_r;
  logic count_rise;

  assign count_rise = count_s & ~count_prev_r;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      count_prev_r <= 1'b0;
    end else if (scan_tick_r) begin
      count_prev_r <= count_s;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      hold_r <= 1'b0;
    end else if (scan_tick_r) begin
      // Set while preset, cleared after one further scan
      hold_r <= preset_s;
    end
  end

  // Current value
  logic [DATA_W-1:0] cur_r;
  logic [DATA_W-1:0] cur_nxt;
  logic [DATA_W-1:0] cur_lim;

  assign cur_lim = cur_r & max_v;

  always_comb begin
    cur_nxt = cur_lim;
    if (preset_s) begin
      cur_nxt = init_lim;
    end else if (!hold_r && count_rise) begin
      if (down_s) begin
        if (cur_lim != '0) begin
          cur_nxt = cur_lim - DATA_W'(1);
        end
      end else if (cur_lim < max_v) begin
        cur_nxt = cur_lim + DATA_W'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cur_r <= CUR_RST;
    end else if (scan_tick_r) begin
      cur_r <= cur_nxt;
    end
  end

  // Comparison output
  logic out_r;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      out_r <= 1'b0;
    end else if (scan_tick_r) begin
      if (preset_s) begin
        out_r <= 1'b0;
      end else begin
        out_r <= cmp_next(cur_nxt, on_lim, off_lim, out_r);
      end
    end
  end

  // Loaded flag: value is only meaningful after one preset
  logic loaded_r;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      loaded_r <= 1'b0;
    end else if (scan_tick_r && preset_s) begin
      loaded_r <= 1'b1;
    end
  end

  assign cmp_out_o = out_r;
  assign cur_value_o = cur_r;

  // Exact match of one register's byte address
  function automatic logic reg_hit(
    input logic [ADDR_W-1:0] a,
    input logic [ADDR_W-1:0] ofs
  );
    reg_hit = (a == ofs);
  endfunction

  // APB slave, zero wait state
  logic pready_r;
  logic pslverr_r;
  logic [DATA_W-1:0] prdata_r;
  logic setup;
  logic access;
  logic aligned;
  logic is_slot;
  logic is_ctrl;
  logic is_status;
  logic is_cur;
  logic mapped;
  logic [DATA_W-1:0] rd_mux;
  logic [DATA_W-1:0] status_v;

  assign setup = psel_i & ~penable_i;
  assign access = psel_i & penable_i & pready_r;
  assign aligned = (paddr_i[1:0] == 2'b00);
  assign is_slot = (paddr_i <= SLOT_END_OFS) && aligned;
  assign is_ctrl = reg_hit(paddr_i, CTRL_OFS);
  assign is_status = reg_hit(paddr_i, STATUS_OFS);
  assign is_cur = reg_hit(paddr_i, CUR_OFS);
  assign mapped = is_slot || is_ctrl || is_status || is_cur;
  assign slot_wr = access && pwrite_i && is_slot;
  assign slot_wr_idx = paddr_i[SLOT_IDX_W+1:2];

  always_comb begin
    status_v = '0;
    status_v[STAT_OUT_BIT] = out_r;
    status_v[STAT_LOADED_BIT] = loaded_r;
    status_v[STAT_HOLD_BIT] = hold_r;
    status_v[STAT_BASE_ERR_BIT] = base_err;
    status_v[STAT_PRESET_BIT] = preset_s;
  end

  always_comb begin
    rd_mux = '0;
    if (is_slot) begin
      rd_mux = {16'h0000, slots[slot_wr_idx*SLOT_W +: SLOT_W]};
    end else if (is_ctrl) begin
      rd_mux = ctrl_r;
    end else if (is_status) begin
      rd_mux = status_v;
    end else if (is_cur) begin
      rd_mux = cur_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctrl_r <= CTRL_RST;
    end else if (access && pwrite_i && is_ctrl) begin
      ctrl_r <= '0;
      ctrl_r[CTRL_DWORD_BIT] <= pwdata_i[CTRL_DWORD_BIT];
      ctrl_r[CTRL_BASE_LSB +: SLOT_IDX_W] <=
        pwdata_i[CTRL_BASE_LSB +: SLOT_IDX_W];
    end
  end

  // Ready and error pulse for one cycle in the access phase
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      pready_r <= 1'b1;
      pslverr_r <= ~mapped;
    end else begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  // Read data captured at setup, shown during access
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      prdata_r <= '0;
    end else if (setup) begin
      prdata_r <= (!pwrite_i && mapped) ? rd_mux : '0;
    end
  end

  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;

endmodule // reversible_counter_block

// ===== updown_asserts.sv
module updown_asserts
  import updown_pkg::*;
(
  // Clock, reset and bus
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [updown_pkg::ADDR_W-1:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [updown_pkg::DATA_W-1:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Counter
  input wire logic preset_load_input_i,
  input wire logic cmp_out_o,
  input wire logic [updown_pkg::DATA_W-1:0] cur_value_o
);
  logic [8:0] low_cnt_r;
  logic [8:0] high_cnt_r;
  logic unmapped;

  // Every address outside the aligned word map
  assign unmapped = (paddr_i > CUR_OFS) || (paddr_i[1:0] != 2'b00);

  // Cycles since preset went low, saturating
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || preset_load_input_i) begin
      low_cnt_r <= 9'h0;
    end else if (low_cnt_r != 9'h12c) begin
      low_cnt_r <= low_cnt_r + 9'h1;
    end
  end

  // Cycles preset has been held, saturating
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !preset_load_input_i) begin
      high_cnt_r <= 9'h0;
    end else if (high_cnt_r != 9'h96) begin
      high_cnt_r <= high_cnt_r + 9'h1;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence apb_setup;
    psel_i && !penable_i;
  endsequence
  sequence apb_done;
    pready_o && psel_i && penable_i;
  endsequence
  property step_p;
    low_cnt_r == 9'h12c && $changed(cur_value_o) |->
      (cur_value_o - $past(cur_value_o) == 32'h1) ||
      ($past(cur_value_o) - cur_value_o == 32'h1);
  endproperty
  property reset_p;
    @(posedge clk_i) disable iff (1'b0)
    sys_rst_i |=> !pready_o && !cmp_out_o && cur_value_o == CUR_RST;
  endproperty

  apb_ready_a: assert property (apb_setup |=> apb_done)
    else $error("ready missing after setup");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  ready_cause_a: assert property (pready_o |-> psel_i && penable_i)
    else $error("ready outside access phase");
  err_unmapped_a: assert property (
    pready_o && unmapped |-> pslverr_o && prdata_o == 32'h0)
    else $error("unmapped access not refused");
  err_cause_a: assert property (pslverr_o |-> pready_o && unmapped)
    else $error("error on mapped access");
  preset_off_a: assert property (high_cnt_r == 9'h96 |-> !cmp_out_o)
    else $error("output on during preset");
  step_one_a: assert property (step_p)
    else $error("value moved by other than one");
  scan_hold_a: assert property (
    $changed(cur_value_o) |=> $stable(cur_value_o) [*8])
    else $error("value changed twice in a scan");
  reset_state_a: assert property (reset_p)
    else $error("outputs not cleared by reset");
endmodule // updown_asserts

bind reversible_counter_block updown_asserts u_chk (
  .clk_i(clk_i),
  .sys_rst_i(sys_rst_i),
  .paddr_i(paddr_i),
  .psel_i(psel_i),
  .penable_i(penable_i),
  .prdata_o(prdata_o),
  .pready_o(pready_o),
  .pslverr_o(pslverr_o),
  .preset_load_input_i(preset_load_input_i),
  .cmp_out_o(cmp_out_o),
  .cur_value_o(cur_value_o)
);

// ===== ctrl_logic_model.sv
module ctrl_logic_model
  import updown_pkg::*;
(
  // Clock and command
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [1:0] op_i,
  // Busy flag and counter inputs
  output logic busy_o,
  output logic preset_o,
  output logic pulse_o,
  output logic down_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 2 * SCAN_CYC;

  // Ops: 0 preset, 1 up, 2 down, 3 preset with early count edge
  initial begin
    busy_o = 1'b0;
    preset_o = 1'b0;
    pulse_o = 1'b0;
    down_o = 1'b0;
    forever begin
      do @(posedge clk_i); while (go_i !== 1'b1);
      busy_o <= 1'b1;
      if (op_i[0] == op_i[1]) begin
        preset_o <= 1'b1; // Preset before trusting the value
        pulse_o <= 1'b0;
        repeat (HOLD) @(posedge clk_i);
        preset_o <= 1'b0;
        pulse_o <= op_i[0];
      end else begin
        down_o <= op_i[1];
        pulse_o <= 1'b0;
        repeat (HOLD) @(posedge clk_i);
        pulse_o <= 1'b1;
      end
      repeat (HOLD) @(posedge clk_i);
      busy_o <= 1'b0;
    end
  end
endmodule // ctrl_logic_model

// ===== test_reversible_counter_block.sv
`define CHK(nm, ex, ac) \
  begin \
    check_count++; \
    if ((ac) !== (ex)) begin \
      num_errors++; \
      $display("Error %s exp %h got %h", nm, ex, ac); \
    end \
  end

module test_reversible_counter_block
  import updown_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [15:0] init;
    logic [15:0] on_t;
    logic [15:0] off_t;
    logic [1:0] op;
    logic [31:0] cur;
    logic out;
  } row_s;
  row_s rows [13] = '{
    '{16'h4, 16'h5, 16'h3, 2'h0, 32'h4, 1'h0},
    '{16'h4, 16'h5, 16'h3, 2'h1, 32'h5, 1'h1},
    '{16'h4, 16'h5, 16'h3, 2'h2, 32'h4, 1'h1},
    '{16'h4, 16'h5, 16'h3, 2'h2, 32'h3, 1'h1},
    '{16'h4, 16'h5, 16'h3, 2'h2, 32'h2, 1'h0},
    '{16'h4, 16'h2, 16'h4, 2'h1, 32'h3, 1'h1},
    '{16'h4, 16'h2, 16'h4, 2'h1, 32'h4, 1'h0},
    '{16'h4, 16'h2, 16'h4, 2'h2, 32'h3, 1'h1},
    '{16'h0, 16'h2, 16'h4, 2'h0, 32'h0, 1'h0},
    '{16'h0, 16'h2, 16'h4, 2'h2, 32'h0, 1'h0},
    '{16'hffff, 16'h2, 16'h4, 2'h0, 32'hffff, 1'h0},
    '{16'hffff, 16'h2, 16'h4, 2'h1, 32'hffff, 1'h0},
    '{16'h6, 16'h5, 16'h3, 2'h0, 32'h6, 1'h1}
  };
  logic [15:0] dw [6] = '{16'hffff, 16'h0, 16'h0, 16'h1, 16'h0, 16'h0};
  logic [15:0] dw2 [6] = '{16'h0, 16'h2, 16'h0, 16'h1, 16'h0, 16'h3};
  logic clk_i = 1'b0;
  logic sys_rst_i, psel, penable, pwrite, go, busy, rde;
  logic preset, pulse, down, pready, pslverr, cmp_out;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, cur, rdq;
  logic [1:0] op;
  int num_errors = 0;
  int check_count = 0;

  always #5 clk_i = ~clk_i;

  reversible_counter_block dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .paddr_i(paddr), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .preset_load_input_i(preset), .count_pulse_i(pulse), .dir_down_i(down),
    .cmp_out_o(cmp_out), .cur_value_o(cur));
  ctrl_logic_model model (.clk_i(clk_i), .go_i(go), .op_i(op),
    .busy_o(busy), .preset_o(preset), .pulse_o(pulse), .down_o(down));

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1) @(posedge clk_i);
    rdq = prdata;
    rde = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic run(input logic [1:0] o);
    op <= o;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    @(posedge clk_i);
    while (busy) @(posedge clk_i);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // About 20 ops of 400 clocks each, with wide margin
  initial begin
    repeat (40000) @(posedge clk_i);
    num_errors++;
    wrap_up;
  end

  initial begin
    sys_rst_i = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    go = 1'b0;
    op = 2'h0;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    rd(CUR_OFS);
    `CHK("cur reset", CUR_RST, rdq)
    rd(12'h100);
    `CHK("unmapped", 1'b1, rde)
    foreach (rows[i]) begin
      wr(SLOT_OFS, {16'h0, rows[i].init});
      wr(SLOT_OFS + 12'h4, {16'h0, rows[i].on_t});
      wr(SLOT_OFS + 12'h8, {16'h0, rows[i].off_t});
      run(rows[i].op);
      `CHK("value", rows[i].cur, cur)
      `CHK("output", rows[i].out, cmp_out)
    end
    wr(CTRL_OFS, 32'h1); // Start slot 0 fits the group
    foreach (dw[i]) begin
      wr(SLOT_OFS + 12'(4 * i), {16'h0, dw[i]});
    end
    run(2'h0);
    run(2'h1);
    `CHK("dword step", 32'h0001_0000, cur)
    `CHK("dword out", 1'b1, cmp_out)
    run(2'h3);
    `CHK("early edge", 32'h0000_ffff, cur)
    `CHK("preset out", 1'b0, cmp_out)
    wr(SLOT_OFS + 12'h4, 32'h0000_ffff);
    run(2'h0);
    run(2'h1);
    `CHK("dword max", 32'hffff_ffff, cur)
    wr(CTRL_OFS, 32'h0000_0021); // Start slot 2 fits six slots
    foreach (dw2[i]) begin
      wr(SLOT_OFS + 12'(8 + 4 * i), {16'h0, dw2[i]});
    end
    run(2'h0);
    `CHK("start slot", 32'h0002_0000, cur)
    `CHK("start slot out", 1'b1, cmp_out)
    rd(STATUS_OFS);
    `CHK("status", 32'h0000_0003, rdq)
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    rd(SLOT_OFS + 12'h4);
    `CHK("slot restore", {16'h0, SLOT_RST[1]}, rdq)
    rd(CTRL_OFS);
    `CHK("ctrl restore", CTRL_RST, rdq)
    wrap_up;
  end
endmodule // test_reversible_counter_block
